// >>> src/sbc_spi_slave_command_checker.sv
// Operation
// RULE_01: Sample input on falling clock during select
// RULE_02: Shift next output bit after rising clock
// RULE_03: Select rise interprets word, releases output
// RULE_04: Bad command ignored, sticky fail flag set
// RULE_05: Stop to sleep rejected, restart entered
// RULE_06: Stop/sleep from init gives normal, fail
// RULE_07: Odd watchdog parity fails, discards write
// RULE_08: Stop mode accepts only few commands
// RULE_09: Stop with wake bits pending raises interrupt
// RULE_10: Stop to normal drops other changes
// RULE_11: Sleep without wake source goes restart
// RULE_12: Load share bit cannot be cleared
// RULE_13: Sleep with measured pin wakes only fails
// RULE_14: Timer on-time not below period fails
// RULE_15: All-zero or all-one frame fails
// RULE_16: Only 0 or 16 clocks accepted
// RULE_17: Frame error shown before first rising edge
// RULE_18: Reset-low overlap errors, output driven high
// RULE_19: Address, selector, data byte frame layout
// RULE_20: Status sticky; restart ignores all commands
// RULE_21: Same-frame readback, writes seen later
// RULE_22: Summary byte ORs each status register
// RULE_23: Control and status address windows
// RULE_24: Frame error reported once, then cleared
module sbc_spi_slave_command_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic chip_select_low_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_out,
  input wire logic reset_output_in,
  input wire logic [2:0] mode_in,
  input wire logic [sbc_spi_pkg::STATUS_COUNT-1:0][7:0] status_set_in,
  input wire logic [7:0] wake_level_in,
  output logic [2:0] mode_request_out,
  output logic mode_request_valid_out,
  output logic wake_pending_irq_out,
  output logic watchdog_trigger_out,
  output logic [7:0] watchdog_setting_out,
  output logic load_share_out,
  output logic [7:0] status_summary_out
);

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  //////////////////////////////////////////////////////////////////////

  logic cs_s1_r, cs_s2_r, cs_s3_r; // Select, third stage for edges
  logic sck_s1_r, sck_s2_r, sck_s3_r; // Serial clock
  logic sdi_s1_r, sdi_s2_r; // Serial data
  logic cs_fall, cs_rise, sck_fall, sck_rise;

  // Two flops before use; the third only feeds edge detection
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      {cs_s1_r, cs_s2_r, cs_s3_r} <= 3'h7;
      {sck_s1_r, sck_s2_r, sck_s3_r} <= 3'h0;
      {sdi_s1_r, sdi_s2_r} <= 2'h0;
    end else begin
      cs_s1_r <= chip_select_low_in;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      sck_s1_r <= serial_clock_in;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      sdi_s1_r <= serial_data_in;
      sdi_s2_r <= sdi_s1_r;
    end
  end

  assign cs_fall = cs_s3_r & ~cs_s2_r;
  assign cs_rise = ~cs_s3_r & cs_s2_r;
  assign sck_fall = sck_s3_r & ~sck_s2_r & ~cs_s2_r;
  assign sck_rise = ~sck_s3_r & sck_s2_r & ~cs_s2_r;

  //////////////////////////////////////////////////////////////////////
  // Frame state, shift register and counters
  //////////////////////////////////////////////////////////////////////

  sbc_spi_pkg::frame_state_type state_r; // Frame tracker
  logic [15:0] rx_r; // Received word, first bit lands in bit 0
  logic [4:0] fall_cnt_r; // Falling edges seen, saturating
  logic [4:0] rise_cnt_r; // Rising edges seen, saturating
  logic edge_bad_r; // Clock high at a select edge
  logic overlap_r; // Reset output low during this frame
  logic err_pend_r; // Frame error waiting to be reported
  logic frame_bad;

  // Idle until select falls, done for one cycle after it rises
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= sbc_spi_pkg::FRAME_IDLE;
    end else begin
      case (state_r)
        sbc_spi_pkg::FRAME_IDLE: begin
          if (cs_fall) state_r <= sbc_spi_pkg::FRAME_BUSY;
        end
        sbc_spi_pkg::FRAME_BUSY: begin
          if (cs_rise) state_r <= sbc_spi_pkg::FRAME_DONE; // [RULE_03]
        end
        default: begin
          state_r <= sbc_spi_pkg::FRAME_IDLE;
        end
      endcase
    end
  end

  // Shift in on each falling clock; counters restart at select fall
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_r <= 16'h0000;
      fall_cnt_r <= 5'h00;
      rise_cnt_r <= 5'h00;
    end else if (cs_fall) begin
      fall_cnt_r <= 5'h00;
      rise_cnt_r <= 5'h00;
    end else begin
      if (sck_fall) begin
        rx_r <= {sdi_s2_r, rx_r[15:1]}; // [RULE_01]
        if (fall_cnt_r != sbc_spi_pkg::CLK_SAT) begin
          fall_cnt_r <= fall_cnt_r + 5'h01;
        end
      end
      if (sck_rise && rise_cnt_r != sbc_spi_pkg::CLK_SAT) begin
        rise_cnt_r <= rise_cnt_r + 5'h01;
      end
    end
  end

  // Clock high at either select edge spoils the frame
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      edge_bad_r <= 1'b0;
    end else if (cs_fall) begin
      edge_bad_r <= sck_s2_r; // [RULE_16]
    end else if (cs_rise && sck_s2_r) begin
      edge_bad_r <= 1'b1; // [RULE_16]
    end
  end

  // Any reset-low time inside a frame spoils it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      overlap_r <= 1'b0;
    end else if (cs_fall) begin
      overlap_r <= ~reset_output_in; // [RULE_18]
    end else if (!cs_s2_r && !reset_output_in) begin
      overlap_r <= 1'b1; // [RULE_18]
    end
  end

  assign frame_bad = edge_bad_r || overlap_r ||
    (fall_cnt_r != sbc_spi_pkg::CLK_NONE &&
     fall_cnt_r != sbc_spi_pkg::CLK_FULL);

  // Error waits for the next frame; the report consumes it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      err_pend_r <= 1'b0;
    end else if (state_r == sbc_spi_pkg::FRAME_DONE && frame_bad) begin
      err_pend_r <= 1'b1; // [RULE_16]
    end else if (cs_fall) begin
      err_pend_r <= 1'b0; // [RULE_24]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registers
  //////////////////////////////////////////////////////////////////////

  logic [7:0] ctrl_mem [0:31]; // Control bytes by address
  logic [7:0] status_r [sbc_spi_pkg::STATUS_COUNT]; // Sticky status
  logic [sbc_spi_pkg::STATUS_COUNT-1:0] stat_hit; // Address match
  logic [7:0] summary; // Live summary byte
  logic [7:0] summary_r; // Summary frozen at select fall

  logic [6:0] addr;
  logic sel;
  logic [7:0] dat;
  logic [7:0] old;
  assign addr = rx_r[sbc_spi_pkg::ADDR_HI:0]; // [RULE_19]
  assign sel = rx_r[sbc_spi_pkg::SEL_BIT]; // [RULE_19]
  assign dat = rx_r[15:sbc_spi_pkg::DATA_LO]; // [RULE_19]
  assign old = ctrl_mem[addr[4:0]];

  logic accept; // Frame may be interpreted
  logic fail; // Forbidden command seen
  logic store; // Write the control byte
  logic [7:0] store_val;
  logic req_v; // Mode request
  sbc_spi_pkg::mode_type req_m;
  logic irq; // Wake bits pending at stop entry
  logic wd_trig; // Watchdog write with even parity

  // Per status register: hardware set wins over software clear
  genvar gi;
  generate
    for (gi = 0; gi < sbc_spi_pkg::STATUS_COUNT; gi++) begin : g_stat
      logic [7:0] fail_set;
      assign stat_hit[gi] = addr == sbc_spi_pkg::STATUS_ADDR[gi];
      assign fail_set = (gi == sbc_spi_pkg::DEVICE_STATUS_IDX && fail) ?
        8'h01 << sbc_spi_pkg::SPI_FAIL_BIT : 8'h00;
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          status_r[gi] <= 8'h00;
        end else if (accept && sel && stat_hit[gi]) begin
          status_r[gi] <= status_set_in[gi] | fail_set; // [RULE_20]
        end else begin
          status_r[gi] <= status_r[gi] | status_set_in[gi] | fail_set;
        end
      end
    end
    for (gi = 0; gi < 8; gi++) begin : g_sum
      if (gi == sbc_spi_pkg::SUMMARY_WAKE_BIT) begin : g_wake
        assign summary[gi] = |status_r[sbc_spi_pkg::WAKE_ONE_IDX] |
          (|status_r[sbc_spi_pkg::WAKE_TWO_IDX]); // [RULE_22]
      end else begin : g_one
        assign summary[gi] =
          |status_r[sbc_spi_pkg::SUMMARY_IDX[gi]]; // [RULE_22]
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Command interpretation
  //////////////////////////////////////////////////////////////////////

  logic [7:0] bus1, wk1, wk2, tmr1, tmr2;
  logic no_wake, meas_only, timer_off_only, stuck, in_stop;
  logic [1:0] req;
  assign bus1 = ctrl_mem[sbc_spi_pkg::BUS_CTRL_ONE_ADDR[4:0]];
  assign wk1 = ctrl_mem[sbc_spi_pkg::WAKE_CTRL_ONE_ADDR[4:0]];
  assign wk2 = ctrl_mem[sbc_spi_pkg::WAKE_CTRL_TWO_ADDR[4:0]];
  assign tmr1 = ctrl_mem[sbc_spi_pkg::TIMER_ONE_ADDR[4:0]];
  assign tmr2 = ctrl_mem[sbc_spi_pkg::TIMER_TWO_ADDR[4:0]];
  assign no_wake = bus1 == 8'h00 && wk2 == 8'h00;
  assign meas_only = wk1[sbc_spi_pkg::MEASURE_BIT] && bus1 == 8'h00 &&
    wk2 != 8'h00 && (wk2 & ~sbc_spi_pkg::WAKE_PIN_MASK) == 8'h00;
  // Timer-only wake with that timer off can never wake from sleep
  assign timer_off_only = bus1 == 8'h00 && wk2 != 8'h00 &&
    (wk2 & ~sbc_spi_pkg::TIMER_WAKE_MASK) == 8'h00 &&
    (!wk2[sbc_spi_pkg::TIMER_ONE_WAKE_BIT] ||
     tmr1[sbc_spi_pkg::ON_HI:sbc_spi_pkg::ON_LO] ==
       sbc_spi_pkg::TIMER_OFF) &&
    (!wk2[sbc_spi_pkg::TIMER_TWO_WAKE_BIT] ||
     tmr2[sbc_spi_pkg::ON_HI:sbc_spi_pkg::ON_LO] ==
       sbc_spi_pkg::TIMER_OFF);
  assign stuck = rx_r == sbc_spi_pkg::STUCK_LOW ||
    rx_r == sbc_spi_pkg::STUCK_HIGH;
  assign in_stop = mode_in == sbc_spi_pkg::MODE_STOP;
  assign req = dat[sbc_spi_pkg::MODE_HI:sbc_spi_pkg::MODE_LO];
  // Restart mode and bad frames are never interpreted
  assign accept = state_r == sbc_spi_pkg::FRAME_DONE && !frame_bad &&
    fall_cnt_r == sbc_spi_pkg::CLK_FULL &&
    mode_in != sbc_spi_pkg::MODE_RESTART && !stuck; // [RULE_20]

  // Decide store, failure and mode request for a finished frame
  always_comb begin
    fail = 1'b0;
    store = 1'b0;
    store_val = dat;
    req_v = 1'b0;
    req_m = sbc_spi_pkg::MODE_NORMAL;
    irq = 1'b0;
    wd_trig = 1'b0;
    if (state_r == sbc_spi_pkg::FRAME_DONE && !frame_bad &&
        fall_cnt_r == sbc_spi_pkg::CLK_FULL && stuck &&
        mode_in != sbc_spi_pkg::MODE_RESTART) begin
      fail = 1'b1; // [RULE_15]
    end else if (accept && sel && !addr[sbc_spi_pkg::STATUS_SPACE_BIT] &&
                 addr <= sbc_spi_pkg::CTRL_LAST_ADDR) begin // [RULE_23]
      case (addr)
        sbc_spi_pkg::MODE_CTRL_ADDR: begin
          if (in_stop) begin
            if (req == sbc_spi_pkg::REQ_SLEEP) begin
              fail = 1'b1; // [RULE_05]
              req_v = 1'b1;
              req_m = sbc_spi_pkg::MODE_RESTART;
            end else if (req == sbc_spi_pkg::REQ_NORMAL) begin
              req_v = 1'b1; // [RULE_10]
              store = 1'b1;
              store_val = {sbc_spi_pkg::REQ_NORMAL, old[5:0]};
              fail = dat[5:0] != old[5:0]; // [RULE_10]
            end else if (req == sbc_spi_pkg::REQ_SOFT_RESET) begin
              req_v = 1'b1; // [RULE_08]
              req_m = sbc_spi_pkg::MODE_SOFT_RESET;
            end else begin
              fail = dat != old; // [RULE_08]
            end
          end else if (mode_in == sbc_spi_pkg::MODE_INIT &&
                       (req == sbc_spi_pkg::REQ_SLEEP ||
                        req == sbc_spi_pkg::REQ_STOP)) begin
            fail = 1'b1; // [RULE_06]
            req_v = 1'b1;
            store = 1'b1;
            store_val = {sbc_spi_pkg::REQ_NORMAL, dat[5:0]};
          end else begin
            store = 1'b1;
            req_v = 1'b1;
            case (req)
              sbc_spi_pkg::REQ_STOP: begin
                req_m = sbc_spi_pkg::MODE_STOP;
                irq = |status_r[sbc_spi_pkg::WAKE_ONE_IDX] ||
                  |status_r[sbc_spi_pkg::WAKE_TWO_IDX]; // [RULE_09]
              end
              sbc_spi_pkg::REQ_SOFT_RESET: begin
                req_m = sbc_spi_pkg::MODE_SOFT_RESET;
              end
              sbc_spi_pkg::REQ_SLEEP: begin
                if (no_wake || meas_only) begin
                  fail = 1'b1; // [RULE_11] [RULE_13]
                  req_m = sbc_spi_pkg::MODE_RESTART;
                  store_val = {sbc_spi_pkg::REQ_NORMAL, dat[5:0]};
                end else if (timer_off_only) begin
                  req_m = sbc_spi_pkg::MODE_RESTART; // [RULE_11]
                end else begin
                  req_m = sbc_spi_pkg::MODE_SLEEP;
                end
              end
              default: begin
                req_m = sbc_spi_pkg::MODE_NORMAL;
              end
            endcase
          end
        end
        sbc_spi_pkg::WATCHDOG_CONTROL_REG_ADDR: begin
          if (^dat) begin
            fail = 1'b1; // [RULE_07]
          end else begin
            wd_trig = 1'b1; // [RULE_08]
            store = !in_stop || dat == old;
            fail = in_stop && dat != old; // [RULE_08]
          end
        end
        default: begin
          if (in_stop) begin
            fail = 1'b1; // [RULE_08]
          end else if ((addr == sbc_spi_pkg::TIMER_ONE_ADDR ||
                        addr == sbc_spi_pkg::TIMER_TWO_ADDR) &&
                       dat[sbc_spi_pkg::ON_HI:sbc_spi_pkg::ON_LO] !=
                         sbc_spi_pkg::TIMER_OFF &&
                       dat[sbc_spi_pkg::ON_HI:sbc_spi_pkg::ON_LO] >=
                       dat[sbc_spi_pkg::PERIOD_HI:sbc_spi_pkg::PERIOD_LO])
          begin
            fail = 1'b1; // [RULE_14]
          end else begin
            store = 1'b1;
            if (addr == sbc_spi_pkg::HW_CTRL_ADDR &&
                old[sbc_spi_pkg::LOAD_SHARE_BIT] &&
                !dat[sbc_spi_pkg::LOAD_SHARE_BIT]) begin
              store_val[sbc_spi_pkg::LOAD_SHARE_BIT] = 1'b1; // [RULE_12]
              fail = 1'b1; // [RULE_12]
            end
          end
        end
      endcase
    end
  end

  // Control bytes change only after the frame ends
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 32; i++) ctrl_mem[i] <= sbc_spi_pkg::CTRL_RESET;
    end else if (store) begin
      ctrl_mem[addr[4:0]] <= store_val; // [RULE_04] [RULE_21]
    end
  end

  // Requests to the mode machine and watchdog, one-cycle pulses
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_request_valid_out <= 1'b0;
      mode_request_out <= sbc_spi_pkg::MODE_NORMAL;
      wake_pending_irq_out <= 1'b0;
      watchdog_trigger_out <= 1'b0;
    end else begin
      mode_request_valid_out <= req_v;
      mode_request_out <= req_m;
      wake_pending_irq_out <= irq; // [RULE_09]
      watchdog_trigger_out <= wd_trig;
    end
  end

  // Settings seen by neighbouring blocks
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      watchdog_setting_out <= 8'h00;
      load_share_out <= 1'b0;
      status_summary_out <= 8'h00;
    end else begin
      watchdog_setting_out <= ctrl_mem[sbc_spi_pkg::WATCHDOG_CONTROL_REG_ADDR[4:0]];
      load_share_out <=
        ctrl_mem[sbc_spi_pkg::HW_CTRL_ADDR[4:0]][sbc_spi_pkg::LOAD_SHARE_BIT];
      status_summary_out <= summary;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Serial output
  //////////////////////////////////////////////////////////////////////

  logic [7:0] read_byte; // Byte of the addressed register
  logic [4:0] out_idx; // Word bit shown after this rising edge
  logic out_bit;
  logic [6:0] rd_addr_r; // Address of the running frame

  // The word register keeps moving during a frame, so the address is
  // caught as its seventh bit lands, before the data half goes out
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_addr_r <= 7'h00;
    end else if (sck_fall && fall_cnt_r == 5'(sbc_spi_pkg::ADDR_HI)) begin
      rd_addr_r <= {sdi_s2_r, rx_r[15:10]}; // [RULE_21]
    end
  end

  // Byte returned in the same frame, taken before any write lands
  always_comb begin
    read_byte = 8'h00;
    if (!rd_addr_r[sbc_spi_pkg::STATUS_SPACE_BIT]) begin
      if (rd_addr_r <= sbc_spi_pkg::CTRL_LAST_ADDR) begin
        read_byte = ctrl_mem[rd_addr_r[4:0]]; // [RULE_21]
      end
    end else if (rd_addr_r == sbc_spi_pkg::WAKE_LEVEL_ADDR) begin
      read_byte = wake_level_in;
    end else begin
      for (int i = 0; i < sbc_spi_pkg::STATUS_COUNT; i++) begin
        if (rd_addr_r == sbc_spi_pkg::STATUS_ADDR[i]) begin
          read_byte = status_r[i]; // [RULE_21]
        end
      end
    end
  end

  assign out_idx = rise_cnt_r + 5'h01;
  assign out_bit = out_idx < 5'h08 ? summary_r[out_idx[2:0]] :
    out_idx < 5'h10 ? read_byte[out_idx[2:0]] : 1'b0;

  // Output flop: high under reset, error bit first, then the word
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      serial_data_out <= 1'b1;
      serial_data_oe_out <= 1'b0;
      summary_r <= 8'h00;
    end else begin
      serial_data_oe_out <= !reset_output_in || !cs_s2_r; // [RULE_03]
      if (!reset_output_in) begin
        serial_data_out <= 1'b1; // [RULE_18]
      end else if (cs_fall) begin
        summary_r <= summary;
        serial_data_out <= err_pend_r | summary[0]; // [RULE_17]
      end else if (sck_rise) begin
        serial_data_out <= out_bit; // [RULE_02]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  //////////////////////////////////////////////////////////////////////

  a_err_first_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cs_fall && err_pend_r && reset_output_in |=> serial_data_out) // [RULE_17]
    else $error("pending frame error not shown first");

  a_err_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cs_fall && state_r != sbc_spi_pkg::FRAME_DONE |=> !err_pend_r) // [RULE_24]
    else $error("frame error not cleared after report");

  a_count_error: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == sbc_spi_pkg::FRAME_DONE && fall_cnt_r != 5'h00 &&
    fall_cnt_r != 5'h10 |=> err_pend_r && !$past(store)) // [RULE_16]
    else $error("bad clock count not flagged");

  a_restart_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mode_in == sbc_spi_pkg::MODE_RESTART |-> !store && !req_v) // [RULE_20]
    else $error("command interpreted in restart");

  a_fail_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    status_r[3][0] && !(accept && sel && stat_hit[3]) |=>
    status_r[3][0]) // [RULE_04]
    else $error("failure flag dropped without clear");

  a_stuck_fail: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fail |=> status_r[3][0] ##1 status_r[3][0]) // [RULE_15]
    else $error("failure not recorded");

  a_reset_high: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_18]
    !reset_output_in [*2] |-> serial_data_out && serial_data_oe_out)
    else $error("output not high during reset");

  a_release: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cs_s2_r && reset_output_in ##1 cs_s2_r && reset_output_in |->
    !serial_data_oe_out) // [RULE_03]
    else $error("output driven outside frame");

  a_stop_sleep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    accept && sel && addr == 7'h01 && in_stop && req == 2'h1 |=>
    mode_request_valid_out && mode_request_out == 3'b100) // [RULE_05]
    else $error("stop to sleep not sent to restart");

  a_share_kept: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    load_share_out |=> ##1 load_share_out) // [RULE_12]
    else $error("load share bit cleared");

endmodule : sbc_spi_slave_command_checker

// >>> src/sbc_spi_pkg.sv
package sbc_spi_pkg;

  // Frame geometry and clock counts
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] CLK_NONE = 5'h00; // Error probe frame
  localparam logic [4:0] CLK_FULL = 5'h10; // Complete frame
  localparam logic [4:0] CLK_SAT = 5'h11; // Counter ceiling
  localparam logic [15:0] STUCK_LOW = 16'h0000;
  localparam logic [15:0] STUCK_HIGH = 16'hFFFF;

  // Frame field positions
  localparam int ADDR_HI = 6;
  localparam int SEL_BIT = 7;
  localparam int DATA_LO = 8;
  localparam int STATUS_SPACE_BIT = 6;

  // Control register addresses
  localparam logic [6:0] MODE_CTRL_ADDR = 7'h01;
  localparam logic [6:0] HW_CTRL_ADDR = 7'h02;
  localparam logic [6:0] WATCHDOG_CONTROL_REG_ADDR = 7'h03;
  localparam logic [6:0] BUS_CTRL_ONE_ADDR = 7'h04;
  localparam logic [6:0] WAKE_CTRL_ONE_ADDR = 7'h06;
  localparam logic [6:0] WAKE_CTRL_TWO_ADDR = 7'h07;
  localparam logic [6:0] TIMER_ONE_ADDR = 7'h0C;
  localparam logic [6:0] TIMER_TWO_ADDR = 7'h0D;
  localparam logic [6:0] CTRL_LAST_ADDR = 7'h1E;
  localparam logic [6:0] WAKE_LEVEL_ADDR = 7'h48;

  // Status registers: supply two, supply one, thermal, device, bus,
  // wake one, wake two, switch overload, switch open load
  localparam int STATUS_COUNT = 9;
  localparam logic [6:0] STATUS_ADDR [STATUS_COUNT] = '{7'h40, 7'h41,
    7'h42, 7'h43, 7'h44, 7'h46, 7'h47, 7'h54, 7'h55};
  localparam int DEVICE_STATUS_IDX = 3;
  localparam int WAKE_ONE_IDX = 5;
  localparam int WAKE_TWO_IDX = 6;
  localparam int SPI_FAIL_BIT = 0;
  // Summary bit n reports status register SUMMARY_IDX[n]; bit SUMMARY_WAKE_BIT reports wake one and wake two
  localparam int SUMMARY_IDX [8] = '{1, 2, 3, 4, 5, 0, 7, 8};
  localparam int SUMMARY_WAKE_BIT = 4;

  // Control fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_SLEEP = 2'h1;
  localparam logic [1:0] REQ_STOP = 2'h2;
  localparam logic [1:0] REQ_SOFT_RESET = 2'h3;
  localparam int LOAD_SHARE_BIT = 2;
  localparam int MEASURE_BIT = 7;
  localparam logic [7:0] WAKE_PIN_MASK = 8'h03;
  localparam logic [7:0] TIMER_WAKE_MASK = 8'h30;
  localparam int TIMER_ONE_WAKE_BIT = 4;
  localparam int TIMER_TWO_WAKE_BIT = 5;
  localparam int PERIOD_HI = 2;
  localparam int PERIOD_LO = 0;
  localparam int ON_HI = 6;
  localparam int ON_LO = 4;
  localparam logic [2:0] TIMER_OFF = 3'h0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Operating modes reported by and requested from the mode machine
  typedef enum logic [2:0] {
    MODE_INIT = 3'b000,
    MODE_NORMAL = 3'b001,
    MODE_STOP = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_RESTART = 3'b100,
    MODE_FAILSAFE = 3'b101,
    MODE_SOFT_RESET = 3'b110
  } mode_type;

  // Frame tracking states
  typedef enum logic [1:0] {
    FRAME_IDLE = 2'b00,
    FRAME_BUSY = 2'b01,
    FRAME_DONE = 2'b10
  } frame_state_type;

endpackage : sbc_spi_pkg

// >>> tb/mcu_model.sv
// Controller side: clock idles low, pins move on falling clk_in
module mcu_model (
  input wire logic clk_in,
  input wire logic miso_in,
  output logic sel_n_out,
  output logic sck_out,
  output logic mosi_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sel_n_out = 1'b1;
    sck_out = 1'b0;
    mosi_out = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk_in);
  endtask : gap
  // One frame of n clocks, LSB first; reply bit read before each rise
  task automatic xfer(input logic [15:0] w, input int n,
      output logic [15:0] r);
    r = 16'h0000;
    sel_n_out = 1'b0; // Clock low at select edges
    gap(8);
    for (int i = 0; i < n; i++) begin
      r[i] = miso_in;
      sck_out = 1'b1;
      mosi_out = w[i];
      gap(4);
      sck_out = 1'b0;
      gap(4);
    end
    sel_n_out = 1'b1;
    mosi_out = ~mosi_out; // Released line must not keep its value
    gap(12);
  endtask : xfer
endmodule : mcu_model

// >>> tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ro = 1'b1;
  logic [2:0] mode = 3'h0;
  logic [8:0][7:0] st = '0;
  logic sel_n, sck, mosi, sdo, oe, vld, ls, irq, wdt;
  logic [15:0] irq_n = '0, wdt_n = '0;
  logic last = 1'b0;
  logic [2:0] req, got;
  logic [7:0] sum, wds;
  logic [15:0] r;
  int errors = 0;
  int num_checks = 0;
  wire miso = oe ? sdo : ~last; // Released output reads as the inverse of the last driven bit
  always #12.5 clk_in = ~clk_in;
  // Latch last driven bit and last mode request
  always @(posedge clk_in) begin
    if (oe) last <= sdo;
    if (vld) got <= req;
    if (irq) irq_n <= irq_n + 16'h0001;
    if (wdt) wdt_n <= wdt_n + 16'h0001;
  end
  sbc_spi_slave_command_checker i_sbc_spi_slave_command_checker (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .chip_select_low_in(sel_n),
    .serial_clock_in(sck), .serial_data_in(mosi),
    .serial_data_out(sdo), .serial_data_oe_out(oe),
    .reset_output_in(ro), .mode_in(mode), .status_set_in(st),
    .wake_level_in(8'h00), .mode_request_out(req),
    .mode_request_valid_out(vld), .wake_pending_irq_out(irq),
    .watchdog_trigger_out(wdt), .watchdog_setting_out(wds),
    .load_share_out(ls), .status_summary_out(sum));
  mcu_model i_mcu_model (.clk_in(clk_in), .miso_in(miso),
    .sel_n_out(sel_n), .sck_out(sck), .mosi_out(mosi));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic fr(input logic [15:0] w, input int n);
    i_mcu_model.xfer(w, n, r);
  endtask : fr
  task automatic t_share;
    fr(16'h0482, 16);
    chk("share", 16'h0001, {15'h0, ls});
    fr(16'h0002, 16);
    chk("readback", 16'h0004, {8'h0, r[15:8]});
    fr(16'h0082, 16);
    fr(16'h00C3, 16);
    chk("kept", 16'h0001, {15'h0, ls});
    chk("fail", 16'h0104, {r[15:8], r[7:0]});
    fr(16'h0043, 16);
    chk("cleared", 16'h0000, r);
    $display("share done");
  endtask : t_share
  task automatic t_mode;
    fr(16'h8081, 16);
    chk("init", {13'h0, sbc_spi_pkg::MODE_NORMAL}, {13'h0, got});
    mode = sbc_spi_pkg::MODE_STOP;
    fr(16'h4081, 16);
    chk("stop", {13'h0, sbc_spi_pkg::MODE_RESTART}, {13'h0, got});
    mode = sbc_spi_pkg::MODE_NORMAL;
    fr(16'h00C3, 16);
    chk("failed", 16'h0001, {8'h0, r[15:8]});
    $display("mode done");
  endtask : t_mode
  task automatic t_frame;
    fr(16'h0482, 8);
    fr(16'h0043, 16);
    chk("err", 16'h0001, r);
    fr(16'hFFFF, 16);
    chk("once", 16'h0000, {15'h0, r[0]});
    fr(16'h00C3, 16);
    chk("stuck", 16'h0001, {8'h0, r[15:8]});
    ro = 1'b0;
    i_mcu_model.gap(4);
    chk("ro low", 16'h0003, {14'h0, oe, sdo});
    fr(16'h0043, 16);
    ro = 1'b1;
    fr(16'h0043, 16);
    chk("ro err", 16'h0001, {15'h0, r[0]});
    $display("frame done");
  endtask : t_frame
  task automatic t_sum;
    st[7] = 8'h01;
    st[6] = 8'h02;
    i_mcu_model.gap(1);
    st = '0;
    i_mcu_model.gap(4);
    chk("sum", 16'h0050, {8'h0, sum});
    fr(16'h00D4, 16);
    chk("rc", 16'h0150, r);
    chk("sum2", 16'h0010, {8'h0, sum});
    $display("summary done");
  endtask : t_sum
  task automatic t_misc;
    fr(16'h0783, 16);
    chk("wd odd", 16'h0000, wdt_n);
    fr(16'h0383, 16);
    chk("wd trig", 16'h0001, wdt_n);
    chk("wd set", 16'h0003, {8'h0, wds});
    fr(16'h00C3, 16);
    chk("wd fail", 16'h0001, {8'h0, r[15:8]});
    fr(16'h8081, 16);
    chk("irq", 16'h0001, irq_n);
    fr(16'h0043, 16);
    chk("no fail", 16'h0000, {8'h0, r[15:8]});
    mode = sbc_spi_pkg::MODE_RESTART;
    fr(16'h00C7, 16);
    mode = sbc_spi_pkg::MODE_NORMAL;
    fr(16'h0047, 16);
    chk("restart", 16'h0002, {8'h0, r[15:8]});
    fr(16'h330C, 16);
    fr(16'h000C, 16);
    chk("timer", 16'h0000, {8'h0, r[15:8]});
    $display("misc done");
  endtask : t_misc
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #2ms;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    i_mcu_model.gap(4);
    t_share();
    t_mode();
    t_frame();
    t_sum();
    t_misc();
    tally_and_finish();
  end
endmodule : tb
